// File: pkg/clock_divisor_control_cfg_if.sv
`timescale 1ns/1ps
// Decoded configuration fields passed to the ratio decoder
interface clock_divisor_control_cfg_if;
  logic [2:0] red_sel;
  logic red_en;
  logic [2:0] osc_sel;
  logic [1:0] post_sel;
  logic [4:0] pre_sel;
  clock_divisor_control_pkg::ratio_t proc_ratio;
  logic [4:0] osc_ratio;
  logic [3:0] post_ratio;
  clock_divisor_control_pkg::prediv_t pre_ratio;
  logic post_reserved;
  modport ctrl (output red_sel, red_en, osc_sel, post_sel, pre_sel,
    input proc_ratio, osc_ratio, post_ratio, pre_ratio, post_reserved);
  modport dec (input red_sel, red_en, osc_sel, post_sel, pre_sel,
    output proc_ratio, osc_ratio, post_ratio, pre_ratio, post_reserved);
endinterface : clock_divisor_control_cfg_if

// File: pkg/clock_divisor_control_pkg.sv
package clock_divisor_control_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [6:0] ratio_t;
  typedef logic [5:0] prediv_t;
endpackage : clock_divisor_control_pkg

// File: pkg/clock_divisor_control_regs.svh
`ifndef CLOCK_DIVISOR_CONTROL_REGS_SVH
`define CLOCK_DIVISOR_CONTROL_REGS_SVH

// Register indices on the plain port (address counts 16-bit registers)
`define CLOCK_DIVISOR_CONTROL_ADDR_W 4
`define CLOCK_DIVISOR_CONTROL_CTRL_ADDR 4'h0
`define CLOCK_DIVISOR_CONTROL_FBD_ADDR 4'h1

// Clock divisor control field positions
`define CLOCK_DIVISOR_CONTROL_ROI_BIT 15
`define CLOCK_DIVISOR_CONTROL_RED_HI 14
`define CLOCK_DIVISOR_CONTROL_RED_LO 12
`define CLOCK_DIVISOR_CONTROL_REN_BIT 11
`define CLOCK_DIVISOR_CONTROL_OSC_HI 10
`define CLOCK_DIVISOR_CONTROL_OSC_LO 8
`define CLOCK_DIVISOR_CONTROL_POST_HI 7
`define CLOCK_DIVISOR_CONTROL_POST_LO 6
`define CLOCK_DIVISOR_CONTROL_PRE_HI 4
`define CLOCK_DIVISOR_CONTROL_PRE_LO 0

// Reset values
`define CLOCK_DIVISOR_CONTROL_ROI_RST 1'h0
`define CLOCK_DIVISOR_CONTROL_RED_RST 3'h3
`define CLOCK_DIVISOR_CONTROL_REN_RST 1'h0
`define CLOCK_DIVISOR_CONTROL_OSC_RST 3'h0
`define CLOCK_DIVISOR_CONTROL_POST_RST 2'h1
`define CLOCK_DIVISOR_CONTROL_PRE_RST 5'h00
`define CLOCK_DIVISOR_CONTROL_FBD_RST 9'h030

`endif

// File: rtl/clock_divisor_control_ratio_dec.sv
`timescale 1ns/1ps
// Pure decode of field codes into divide ratios
module clock_divisor_control_ratio_dec (
  clock_divisor_control_cfg_if.dec cfg
);
  // Processor ratio: 1:1 when disabled, else 2^code for codes up to 110
  always_comb begin
    if (!cfg.red_en) begin
      cfg.proc_ratio = 7'h01;
    end else begin
      case (cfg.red_sel)
        3'h1: cfg.proc_ratio = 7'h02;
        3'h2: cfg.proc_ratio = 7'h04;
        3'h3: cfg.proc_ratio = 7'h08;
        3'h4: cfg.proc_ratio = 7'h10;
        3'h5: cfg.proc_ratio = 7'h20;
        3'h6: cfg.proc_ratio = 7'h40;
        // 111 is beyond the map; treat as the largest ratio
        3'h7: cfg.proc_ratio = 7'h40;
        default: cfg.proc_ratio = 7'h01;
      endcase
    end
  end

  // Oscillator postscaler: codes above 100 saturate at 16
  always_comb begin
    case (cfg.osc_sel)
      3'h0: cfg.osc_ratio = 5'h01;
      3'h1: cfg.osc_ratio = 5'h02;
      3'h2: cfg.osc_ratio = 5'h04;
      3'h3: cfg.osc_ratio = 5'h08;
      default: cfg.osc_ratio = 5'h10;
    endcase
  end

  // PLL output divider; reserved code reported and decoded as 4
  always_comb begin
    cfg.post_reserved = 1'b0;
    case (cfg.post_sel)
      2'h0: cfg.post_ratio = 4'h2;
      2'h1: cfg.post_ratio = 4'h4;
      2'h3: cfg.post_ratio = 4'h8;
      default: begin
        cfg.post_ratio = 4'h4;
        cfg.post_reserved = 1'b1;
      end
    endcase
  end

  // Input prescaler is field plus two
  assign cfg.pre_ratio = {1'b0, cfg.pre_sel} + 6'h02;
endmodule : clock_divisor_control_ratio_dec

// File: rtl/clock_divisor_pll_config.sv
`timescale 1ns/1ps
`include "clock_divisor_control_regs.svh"
module clock_divisor_pll_config (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [`CLOCK_DIVISOR_CONTROL_ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic irq_event_i,
  output logic [6:0] proc_ratio_o,
  output logic [4:0] osc_ratio_o,
  output logic [3:0] post_ratio_o,
  output logic [5:0] pre_ratio_o,
  output logic [8:0] fbd_div_o,
  output logic post_reserved_o
);
  logic roi_q;
  logic [2:0] red_sel_q;
  logic red_en_q;
  logic [2:0] osc_sel_q;
  logic [1:0] post_sel_q;
  logic [4:0] pre_sel_q;
  logic [8:0] fbd_q;
  logic wr_ctrl;
  logic wr_fbd;
  logic [2:0] wr_red;
  logic wr_en_req;
  clock_divisor_control_pkg::reg_word_t ctrl_word;
  clock_divisor_control_pkg::reg_word_t fbd_word;
  clock_divisor_control_cfg_if cfg ();

  assign wr_ctrl = wr_i && (addr_i == `CLOCK_DIVISOR_CONTROL_CTRL_ADDR);
  assign wr_fbd = wr_i && (addr_i == `CLOCK_DIVISOR_CONTROL_FBD_ADDR);
  assign wr_red = wdata_i[`CLOCK_DIVISOR_CONTROL_RED_HI:`CLOCK_DIVISOR_CONTROL_RED_LO];
  assign wr_en_req = wdata_i[`CLOCK_DIVISOR_CONTROL_REN_BIT];

  // Plain fields, written freely
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      roi_q <= `CLOCK_DIVISOR_CONTROL_ROI_RST;
      osc_sel_q <= `CLOCK_DIVISOR_CONTROL_OSC_RST;
      post_sel_q <= `CLOCK_DIVISOR_CONTROL_POST_RST;
      pre_sel_q <= `CLOCK_DIVISOR_CONTROL_PRE_RST;
    end else if (wr_ctrl) begin
      roi_q <= wdata_i[`CLOCK_DIVISOR_CONTROL_ROI_BIT];
      osc_sel_q <= wdata_i[`CLOCK_DIVISOR_CONTROL_OSC_HI:`CLOCK_DIVISOR_CONTROL_OSC_LO];
      post_sel_q <= wdata_i[`CLOCK_DIVISOR_CONTROL_POST_HI:`CLOCK_DIVISOR_CONTROL_POST_LO];
      pre_sel_q <= wdata_i[`CLOCK_DIVISOR_CONTROL_PRE_HI:`CLOCK_DIVISOR_CONTROL_PRE_LO];
    end
  end

  // Select locked while enable is set, judged on the old enable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      red_sel_q <= `CLOCK_DIVISOR_CONTROL_RED_RST;
    end else if (wr_ctrl && !red_en_q) begin
      red_sel_q <= wr_red;
    end
  end

  // Enable: interrupt clear wins over a write so the recovery is never lost.
  // Setting checks the select that will stand after this write.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      red_en_q <= `CLOCK_DIVISOR_CONTROL_REN_RST;
    end else if (roi_q && irq_event_i) begin
      red_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      if (!wr_en_req) begin
        red_en_q <= 1'b0;
      end else if ((red_en_q ? red_sel_q : wr_red) != 3'h0) begin
        red_en_q <= 1'b1;
      end
    end
  end

  // Feedback divisor, 9 bits
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fbd_q <= `CLOCK_DIVISOR_CONTROL_FBD_RST;
    end else if (wr_fbd) begin
      fbd_q <= wdata_i[8:0];
    end
  end

  assign ctrl_word = {roi_q, red_sel_q, red_en_q, osc_sel_q, post_sel_q, 1'b0, pre_sel_q};
  assign fbd_word = {7'h00, fbd_q};

  // Read data one cycle after strobe; unmapped reads return zero
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `CLOCK_DIVISOR_CONTROL_CTRL_ADDR: rdata_o <= ctrl_word;
        `CLOCK_DIVISOR_CONTROL_FBD_ADDR: rdata_o <= fbd_word;
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  assign cfg.red_sel = red_sel_q;
  assign cfg.red_en = red_en_q;
  assign cfg.osc_sel = osc_sel_q;
  assign cfg.post_sel = post_sel_q;
  assign cfg.pre_sel = pre_sel_q;

  clock_divisor_control_ratio_dec u_dec (
    .cfg(cfg.dec)
  );

  // Ratios registered so the clock tree sees glitch-free values
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      proc_ratio_o <= 7'h01;
      osc_ratio_o <= 5'h01;
      post_ratio_o <= 4'h4;
      pre_ratio_o <= 6'h02;
      fbd_div_o <= `CLOCK_DIVISOR_CONTROL_FBD_RST;
      post_reserved_o <= 1'b0;
    end else begin
      proc_ratio_o <= cfg.proc_ratio;
      osc_ratio_o <= cfg.osc_ratio;
      post_ratio_o <= cfg.post_ratio;
      pre_ratio_o <= cfg.pre_ratio;
      fbd_div_o <= fbd_q;
      post_reserved_o <= cfg.post_reserved;
    end
  end

  // Assertions
  select_lock_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    red_en_q |=> $stable(red_sel_q))
    else $error("select changed while enable set");
  zero_sel_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    red_en_q |-> red_sel_q != 3'h0)
    else $error("enable set with zero select");
  irq_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (roi_q && irq_event_i) |=> !red_en_q ##1 proc_ratio_o == 7'h01)
    else $error("interrupt did not restore 1:1");
  one_one_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !red_en_q |=> proc_ratio_o == 7'h01)
    else $error("ratio not 1:1 with enable clear");
  div_two_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (red_en_q && red_sel_q == 3'h1) |=> proc_ratio_o == 7'h02)
    else $error("code 001 not divide by 2");
  div_map_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (red_en_q && red_sel_q inside {[3'h2:3'h6]}) |=> proc_ratio_o == (7'h01 << $past(red_sel_q)))
    else $error("reduction map wrong");
  osc_map_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    osc_sel_q <= 3'h4 |=> osc_ratio_o == (5'h01 << $past(osc_sel_q)))
    else $error("oscillator postscaler wrong");
  pre_map_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    1'b1 |=> pre_ratio_o == {1'b0, $past(pre_sel_q)} + 6'h02)
    else $error("prescaler wrong");
  fbd_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == `CLOCK_DIVISOR_CONTROL_FBD_ADDR) |=> rdata_o[15:9] == 7'h00)
    else $error("feedback upper bits not zero");
  post_map_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    post_sel_q == 2'h3 |=> post_ratio_o == 4'h8)
    else $error("output divider code 11 wrong");

  // A refused enable must leave the bit clear; the interrupt case needs no exclusion
  // because the clear wins there anyway
  reject_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_ctrl && wr_en_req && !red_en_q && wr_red == 3'h0) |=> !red_en_q)
    else $error("enable set although select was zero");

  // With enable clear the new select must be taken, not only held
  select_take_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_ctrl && !red_en_q) |=> red_sel_q == $past(wr_red))
    else $error("select write lost while enable clear");

  // Lower nine bits of the feedback read carry the stored divisor
  fbd_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == `CLOCK_DIVISOR_CONTROL_FBD_ADDR) |=> rdata_o[8:0] == $past(fbd_q))
    else $error("feedback divisor read wrong");

  // Output divider codes 00 and 01
  post_low_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    post_sel_q == 2'h0 |=> post_ratio_o == 4'h2)
    else $error("output divider code 00 wrong");
  post_mid_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    post_sel_q == 2'h1 |=> post_ratio_o == 4'h4)
    else $error("output divider code 01 wrong");

  // Codes past 100 saturate so the tree never sees a zero ratio
  osc_sat_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    osc_sel_q > 3'h4 |=> osc_ratio_o == 5'h10)
    else $error("oscillator postscaler not saturated");

  // Feedback output follows the register one edge later
  fbd_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    1'b1 |=> fbd_div_o == $past(fbd_q))
    else $error("feedback divisor output stale");

  // Select 111 is outside the map; it is held at the largest ratio
  sel_top_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (red_en_q && red_sel_q == 3'h7) |=> proc_ratio_o == 7'h40)
    else $error("select 111 not at largest ratio");

  // Main scenarios
  enable_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(red_en_q));
  irq_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    red_en_q && roi_q && irq_event_i);
  reject_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_ctrl && wr_en_req && !red_en_q && wr_red == 3'h0);
  reserved_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    post_sel_q == 2'h2);
  lock_cov: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_ctrl && red_en_q && wr_red != red_sel_q);
endmodule : clock_divisor_pll_config

// File: tb/clock_divisor_pll_config_tb_top.sv
`timescale 1ns/1ps
`include "clock_divisor_control_regs.svh"
// Counts every comparison and reports a mismatch at once
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module clock_divisor_pll_config_tb_top;
  logic clk_sys_i, rst_i, wr_i, rd_i, irq_event_i;
  logic [`CLOCK_DIVISOR_CONTROL_ADDR_W-1:0] addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic [6:0] proc_ratio_o;
  logic [4:0] osc_ratio_o;
  logic [3:0] post_ratio_o;
  logic [5:0] pre_ratio_o;
  logic [8:0] fbd_div_o;
  logic post_reserved_o;
  int mismatches, comparisons;
  // Reference copy of the register fields
  int recover_on_interrupt, red, en, osc, post, pre, fbd;

  clock_divisor_pll_config uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_event_i(irq_event_i), .proc_ratio_o(proc_ratio_o), .osc_ratio_o(osc_ratio_o),
    .post_ratio_o(post_ratio_o), .pre_ratio_o(pre_ratio_o), .fbd_div_o(fbd_div_o),
    .post_reserved_o(post_reserved_o));

  // 100 MHz system clock
  initial begin
    clk_sys_i = 1'h0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // One-cycle write, then the reference model takes the same word
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_sys_i);
    wr_i <= 1'h0;
    if (a == `CLOCK_DIVISOR_CONTROL_CTRL_ADDR) begin
      if (en == 0) red = d[14:12];
      recover_on_interrupt = d[15];
      osc = d[10:8];
      post = d[7:6];
      pre = d[4:0];
      en = (d[11] && red != 0);
    end else if (a == `CLOCK_DIVISOR_CONTROL_FBD_ADDR) begin
      fbd = d[8:0];
    end
  endtask : wr

  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_sys_i);
    rd_i <= 1'h0;
    #1 `CHK("read data", e, rdata_o)
  endtask : rd

  // Interrupt pulse; only a set recover flag drops the enable
  task automatic irq;
    @(posedge clk_sys_i);
    irq_event_i <= 1'h1;
    @(posedge clk_sys_i);
    irq_event_i <= 1'h0;
    if (recover_on_interrupt != 0) en = 0;
  endtask : irq

  // Reads give the ratio outputs time to follow the last write
  task automatic check_all;
    logic [6:0] p;
    p = (en == 0) ? 7'h01 : ((red == 7) ? 7'h40 : 7'(1 << red));
    rd(`CLOCK_DIVISOR_CONTROL_CTRL_ADDR, {recover_on_interrupt[0], red[2:0], en[0], osc[2:0], post[1:0], 1'h0, pre[4:0]});
    rd(`CLOCK_DIVISOR_CONTROL_FBD_ADDR, {7'h00, fbd[8:0]});
    rd(4'h2, 16'h0000);
    `CHK("processor ratio", p, proc_ratio_o)
    `CHK("osc ratio", 5'((osc > 4) ? 16 : (1 << osc)), osc_ratio_o)
    `CHK("output divider", (post == 3) ? 4'h8 : ((post == 0) ? 4'h2 : 4'h4), post_ratio_o)
    `CHK("reserved code", 1'(post == 2), post_reserved_o)
    `CHK("input prescaler", 6'(pre + 2), pre_ratio_o)
    `CHK("feedback divisor", 9'(fbd), fbd_div_o)
  endtask : check_all

  task automatic close_out;
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin
    rst_i = 1'h1;
    wr_i = 1'h0;
    rd_i = 1'h0;
    irq_event_i = 1'h0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    mismatches = 0;
    comparisons = 0;
    recover_on_interrupt = 0;
    red = 3;
    en = 0;
    osc = 0;
    post = 1;
    pre = 0;
    fbd = 'h30;
    void'($urandom(25));
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    check_all();
    // Every select, postscaler and divider code; code 000 must refuse the enable
    for (int i = 0; i < 8; i++) begin
      wr(`CLOCK_DIVISOR_CONTROL_CTRL_ADDR, 16'h0000);
      wr(`CLOCK_DIVISOR_CONTROL_CTRL_ADDR, {1'h0, i[2:0], 1'h1, i[2:0], i[1:0], 1'h0, i[1:0], i[2:0]});
      check_all();
      // A new select while enabled must be dropped
      wr(`CLOCK_DIVISOR_CONTROL_CTRL_ADDR, {1'h0, ~i[2:0], 1'h1, 11'h000});
      check_all();
    end
    // Interrupt with recovery set, then with it clear
    wr(`CLOCK_DIVISOR_CONTROL_CTRL_ADDR, 16'hA800);
    irq();
    check_all();
    wr(`CLOCK_DIVISOR_CONTROL_CTRL_ADDR, 16'h2800);
    irq();
    check_all();
    // Random traffic, unmapped index included
    repeat (60) begin
      if ($urandom % 4 == 0) irq();
      else wr(4'($urandom % 3), 16'($urandom));
      check_all();
    end
    close_out();
  end
endmodule : clock_divisor_pll_config_tb_top
